/* File: hw/cds_perf_counter.sv */
// one direction's performance cycle counter.
// assumes start and done are single-cycle pulses on clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module cds_perf_counter #(
  parameter int CNT_W = 24
)
(
  input wire logic clk_sys_in, // system clock
  input wire logic sys_rst_in, // sync reset, active high
  input wire logic start_in, // descriptor header programmed
  input wire logic done_in, // last descriptor completed
  output logic [CNT_W-1:0] count_out, // cycles counted
  output logic running_out // counter is running
);
  cds_pkg::cds_cnt_state_t state_ff;
  cds_pkg::cds_cnt_state_t nxt_state;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    case (state_ff)
      cds_pkg::CDS_CNT_IDLE,
      cds_pkg::CDS_CNT_HOLD:
      begin
        // restart from zero on each new header
        if (start_in)
        begin
          nxt_state = cds_pkg::CDS_CNT_RUN;
          nxt_count = '0;
        end
      end
      cds_pkg::CDS_CNT_RUN:
      begin
        // fetch cycles counted too, so run from header to last completion
        nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        if (start_in)
          nxt_count = '0;
        else if (done_in)
          nxt_state = cds_pkg::CDS_CNT_HOLD;
      end
      default:
      begin
        nxt_state = cds_pkg::CDS_CNT_IDLE;
        nxt_count = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      state_ff <= cds_pkg::CDS_CNT_IDLE;
      count_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
    end
  end

  assign count_out = count_ff;
  assign running_out = (state_ff == cds_pkg::CDS_CNT_RUN);
endmodule
`default_nettype wire

/* File: hw/cds_pkg.sv */
// types shared by the chaining dma status bank files.
// assumes nothing of its surroundings.
`default_nettype none
package cds_pkg;
  typedef enum logic [1:0]
  {
    CDS_CNT_IDLE,
    CDS_CNT_RUN,
    CDS_CNT_HOLD
  } cds_cnt_state_t;
endpackage
`default_nettype wire

/* File: hw/cds_regs.svh */
// register offsets, field positions, size codes and version constants for the chaining
// dma status bank; included by the status bank module.
`ifndef CDS_REGS_SVH
`define CDS_REGS_SVH

`define CDS_OFF_WR_HI 8'h20
`define CDS_OFF_WR_LO 8'h24
`define CDS_OFF_RD_HI 8'h28
`define CDS_OFF_RD_LO 8'h2c
`define CDS_OFF_ERR 8'h30
`define CDS_OFF_WR_CTL 8'h00
`define CDS_OFF_RD_CTL 8'h10

`define CDS_VER_MSB 31
`define CDS_VER_LSB 28
`define CDS_SIZE_MSB 23
`define CDS_SIZE_LSB 21
`define CDS_WIDTH_MSB 20
`define CDS_WIDTH_LSB 17
`define CDS_EMPTY_BIT 16
`define CDS_LAST_MSB 15
`define CDS_LAST_LSB 0

`define CDS_SIZE_128 3'h0
`define CDS_SIZE_256 3'h1
`define CDS_SIZE_512 3'h2
`define CDS_SIZE_1024 3'h3
`define CDS_SIZE_2048 3'h4

`define CDS_DESIGN_VERSION 4'h1
`define CDS_ZERO32 32'h0000_0000

`endif

/* File: hw/cds_status_bank.sv */
// chaining dma status bank: read-only status words in the bar2/bar3 window.
// assumes a simple single-cycle register port decoded from bar2 or bar3,
// and dma engine status inputs synchronous to clk_sys_in.
// Functional notes
// - write low word: cycle counter header-to-last-done plus address width.
// - read low word: cycle counter header-to-last-done plus maximum tag count.
// - error word counts bad end-to-end crc digests, valid when forwarded.
// - write high bits 31:28 fixed design version; bits 27:24 reserved zero.
// - write high bits 23:21 payload size code; bits 20:17 reserved zero.
// - read high: request size 23:21, one-hot link width 20:17, 31:24 zero.
// - write high bit 16 set when write descriptor fifo is empty.
// - read high bit 16 set when read descriptor fifo is empty.
// - write high low half holds last completed write descriptor index.
// - read high low half holds last completed read descriptor index.
// - all status fields read-only; host writes to the status offsets leave them unchanged.
// - status words decode at byte offsets 0x20 to 0x30, step four.
`timescale 1ns/1ps
`default_nettype none
`include "cds_regs.svh"
module cds_status_bank #(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 24,
  parameter int IDX_W = 16,
  parameter int ECRC_W = 16
)
(
  input wire logic clk_sys_in, // system clock, 100 mhz
  input wire logic sys_rst_in, // sync reset, active high
  input wire logic bar_hit_in, // access hits bar2 or bar3
  input wire logic rd_en_in, // register read strobe
  input wire logic wr_en_in, // register write strobe
  input wire logic [ADDR_W-1:0] addr_in, // byte offset in window
  output logic [31:0] rd_data_out, // read data
  output logic rd_valid_out, // read data valid pulse
  input wire logic wr_last_done_in, // write dma finished last desc
  input wire logic rd_last_done_in, // read dma finished last desc
  input wire logic wr_fifo_empty_in, // write desc fifo empty
  input wire logic rd_fifo_empty_in, // read desc fifo empty
  input wire logic [IDX_W-1:0] wr_last_idx_in, // last write desc done
  input wire logic [IDX_W-1:0] rd_last_idx_in, // last read desc done
  input wire logic [2:0] payload_size_in, // largest payload size code
  input wire logic [2:0] read_req_size_in, // largest read request code
  input wire logic [3:0] link_width_in, // one-hot negotiated width
  input wire logic [7:0] addr_width_in, // target mem address width
  input wire logic [7:0] tag_limit_field_in, // maximum tag count
  input wire logic ecrc_fwd_en_in, // ecrc forwarding enabled
  input wire logic ecrc_err_in // bad ecrc seen, one pulse
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off[ADDR_W-1:0]);
  endfunction

  // the low-word counter shares 32 bits with an 8-bit info byte
  function automatic logic [31:0] lo_word(input logic [7:0] info,
                                          input logic [CNT_W-1:0] cnt);
    lo_word = {info, cnt};
  endfunction

  // ----------------------------------------------------------------
  // performance counters
  // ----------------------------------------------------------------
  logic wr_start;
  logic rd_start;
  logic [CNT_W-1:0] wr_cnt;
  logic [CNT_W-1:0] rd_cnt;

  assign wr_start = bar_hit_in && wr_en_in && hit(addr_in, `CDS_OFF_WR_CTL);
  assign rd_start = bar_hit_in && wr_en_in && hit(addr_in, `CDS_OFF_RD_CTL);

  cds_perf_counter #(
    .CNT_W(CNT_W)
  )
  u_wr_cnt
  (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .start_in(wr_start),
    .done_in(wr_last_done_in),
    .count_out(wr_cnt),
    .running_out()
  );

  cds_perf_counter #(
    .CNT_W(CNT_W)
  )
  u_rd_cnt
  (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .start_in(rd_start),
    .done_in(rd_last_done_in),
    .count_out(rd_cnt),
    .running_out()
  );

  // ----------------------------------------------------------------
  // ecrc error counter
  // ----------------------------------------------------------------
  logic [ECRC_W-1:0] ecrc_cnt_ff;
  logic [ECRC_W-1:0] nxt_ecrc_cnt;

  always_comb
  begin
    nxt_ecrc_cnt = ecrc_cnt_ff;
    // count bad digests
    // saturate so a flood of errors never wraps back to a small value
    if (ecrc_fwd_en_in && ecrc_err_in && !(&ecrc_cnt_ff))
      nxt_ecrc_cnt = ecrc_cnt_ff + {{(ECRC_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      ecrc_cnt_ff <= '0;
    else
      ecrc_cnt_ff <= nxt_ecrc_cnt;
  end

  // ----------------------------------------------------------------
  // status word assembly
  // ----------------------------------------------------------------
  logic [31:0] wr_hi;
  logic [31:0] rd_hi;
  logic [31:0] err_word;

  always_comb
  begin
    wr_hi = `CDS_ZERO32;
    wr_hi[`CDS_VER_MSB:`CDS_VER_LSB] = `CDS_DESIGN_VERSION;
    wr_hi[`CDS_SIZE_MSB:`CDS_SIZE_LSB] = payload_size_in;
    wr_hi[`CDS_EMPTY_BIT] = wr_fifo_empty_in;
    wr_hi[`CDS_LAST_MSB:`CDS_LAST_LSB] = wr_last_idx_in;
  end

  always_comb
  begin
    rd_hi = `CDS_ZERO32;
    rd_hi[`CDS_SIZE_MSB:`CDS_SIZE_LSB] = read_req_size_in;
    rd_hi[`CDS_WIDTH_MSB:`CDS_WIDTH_LSB] = link_width_in;
    rd_hi[`CDS_EMPTY_BIT] = rd_fifo_empty_in;
    rd_hi[`CDS_LAST_MSB:`CDS_LAST_LSB] = rd_last_idx_in;
  end

  always_comb
  begin
    err_word = `CDS_ZERO32;
    err_word[ECRC_W-1:0] = ecrc_cnt_ff;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [31:0] rd_data_ff;
  logic [31:0] nxt_rd_data;
  logic rd_valid_ff;
  logic nxt_rd_valid;

  always_comb
  begin
    nxt_rd_valid = bar_hit_in && rd_en_in;
    nxt_rd_data = `CDS_ZERO32;
    if (bar_hit_in && rd_en_in)
    begin
      if (hit(addr_in, `CDS_OFF_WR_HI))
        nxt_rd_data = wr_hi;
      else if (hit(addr_in, `CDS_OFF_WR_LO))
        nxt_rd_data = lo_word(addr_width_in, wr_cnt);
      else if (hit(addr_in, `CDS_OFF_RD_HI))
        nxt_rd_data = rd_hi;
      else if (hit(addr_in, `CDS_OFF_RD_LO))
        nxt_rd_data = lo_word(tag_limit_field_in, rd_cnt);
      else if (hit(addr_in, `CDS_OFF_ERR))
        nxt_rd_data = err_word;
    end
  end

  // writes ignored here
  // status words have no write path; only the header offsets are snooped
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      rd_data_ff <= `CDS_ZERO32;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign rd_data_out = rd_data_ff;
  assign rd_valid_out = rd_valid_ff;
endmodule
`default_nettype wire

/* File: tb/cds_host_model.sv */
// host side: issues single-cycle register reads and writes.
// assumes the bank samples the strobes on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module cds_host_model (
  input wire logic clk_in, // bench clock
  output logic bar_hit_out, // window hit
  output logic rd_en_out, // read strobe
  output logic wr_en_out, // write strobe
  output logic [7:0] addr_out // byte offset
);
  initial {bar_hit_out, rd_en_out, wr_en_out, addr_out} = 11'h0;
  task automatic acc(input logic r, input logic [7:0] a);
    @(negedge clk_in);
    {bar_hit_out, rd_en_out, wr_en_out, addr_out} <= {1'b1, r, ~r, a};
    @(negedge clk_in);
    {bar_hit_out, rd_en_out, wr_en_out} <= 3'h0;
    // released offset is scrambled so a stale decode cannot pass
    addr_out <= ~a;
  endtask
endmodule
`default_nettype wire

/* File: tb/cds_status_props.sv */
// checker: read port timing and status word layout of the bank.
// assumes it is bound into cds_status_bank.
`timescale 1ns/1ps
`default_nettype none
module cds_status_props #(
  parameter int ADDR_W = 8,
  parameter int IDX_W = 16
)
(
  input wire logic clk_sys_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic bar_hit_in, // hit
  input wire logic rd_en_in, // read
  input wire logic [ADDR_W-1:0] addr_in, // offset
  input wire logic [31:0] rd_data_out, // data
  input wire logic rd_valid_out, // valid
  input wire logic wr_fifo_empty_in, // empty
  input wire logic rd_fifo_empty_in, // empty
  input wire logic [IDX_W-1:0] wr_last_idx_in, // index
  input wire logic [IDX_W-1:0] rd_last_idx_in, // index
  input wire logic [2:0] payload_size_in, // size
  input wire logic [2:0] read_req_size_in, // size
  input wire logic [3:0] link_width_in, // width
  input wire logic [7:0] addr_width_in, // info
  input wire logic [7:0] tag_limit_field_in // info
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_rd(logic [7:0] a);
    bar_hit_in && rd_en_in && addr_in == a;
  endsequence
  a_read_answer:
    assert property (bar_hit_in && rd_en_in |=> rd_valid_out)
      else $error("read not answered");
  a_valid_only_read:
    assert property (!(bar_hit_in && rd_en_in) |=> !rd_valid_out)
      else $error("valid without read");
  a_idle_quiet:
    assert property (!(bar_hit_in && rd_en_in) |=> rd_data_out == 32'h0)
      else $error("data without read");
  a_unmapped_zero:
    assert property (s_rd(8'h34) |=> rd_data_out == 32'h0)
      else $error("unmapped read not zero");
  a_wr_hi_word:
    assert property (s_rd(8'h20) |=> rd_data_out == {4'h1, 4'h0,
      $past(payload_size_in), 4'h0, $past(wr_fifo_empty_in),
      $past(wr_last_idx_in)}) else $error("write high word");
  a_rd_hi_word:
    assert property (s_rd(8'h28) |=> rd_data_out == {8'h00,
      $past(read_req_size_in), $past(link_width_in),
      $past(rd_fifo_empty_in), $past(rd_last_idx_in)})
      else $error("read high word");
  a_wr_lo_info:
    assert property (s_rd(8'h24) |=>
      rd_data_out[31:24] == $past(addr_width_in))
      else $error("write low info");
  a_rd_lo_info:
    assert property (s_rd(8'h2c) |=>
      rd_data_out[31:24] == $past(tag_limit_field_in)) else $error("tag info");
  a_err_upper_zero:
    assert property (s_rd(8'h30) |=> rd_data_out[31:16] == 16'h0)
      else $error("error word upper bits");
endmodule
bind cds_status_bank cds_status_props #(.ADDR_W(ADDR_W), .IDX_W(IDX_W))
  props_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
  .bar_hit_in(bar_hit_in), .rd_en_in(rd_en_in), .addr_in(addr_in),
  .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
  .wr_fifo_empty_in(wr_fifo_empty_in), .rd_fifo_empty_in(rd_fifo_empty_in),
  .wr_last_idx_in(wr_last_idx_in), .rd_last_idx_in(rd_last_idx_in),
  .payload_size_in(payload_size_in), .read_req_size_in(read_req_size_in),
  .link_width_in(link_width_in), .addr_width_in(addr_width_in),
  .tag_limit_field_in(tag_limit_field_in));
`default_nettype wire

/* File: tb/tb_top.sv */
// bench: reads the status words, drives dma status and counter events.
// assumes cds_host_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic bar_hit, rd_en, wr_en, wl_done, rl_done, we, re, fwd, ecrc, rd_valid;
  logic [7:0] addr, aw, tl;
  logic [15:0] wi, ri;
  logic [2:0] ps, rs;
  logic [3:0] lw;
  logic [31:0] rd_data;
  logic [31:0] q[$];
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 32;
  always #5 clk_sys_in = ~clk_sys_in;
  cds_host_model cds_host_model_i (.clk_in(clk_sys_in), .bar_hit_out(bar_hit),
    .rd_en_out(rd_en), .wr_en_out(wr_en), .addr_out(addr));
  cds_status_bank cds_status_bank_i (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .bar_hit_in(bar_hit), .rd_en_in(rd_en),
    .wr_en_in(wr_en), .addr_in(addr), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .wr_last_done_in(wl_done),
    .rd_last_done_in(rl_done), .wr_fifo_empty_in(we),
    .rd_fifo_empty_in(re), .wr_last_idx_in(wi), .rd_last_idx_in(ri),
    .payload_size_in(ps), .read_req_size_in(rs), .link_width_in(lw),
    .addr_width_in(aw), .tag_limit_field_in(tl), .ecrc_fwd_en_in(fwd),
    .ecrc_err_in(ecrc));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q.push_back(exp);
    cds_host_model_i.acc(1'b1, a);
  endtask
  // header edge loads zero; count then rises on each edge up to and including the done edge, g+1 in all
  task automatic run(input logic [7:0] h, input int g);
    cds_host_model_i.acc(1'b0, h);
    repeat (g) @(negedge clk_sys_in);
    {wl_done, rl_done} = {h == 8'h00, h == 8'h10};
    @(negedge clk_sys_in);
    {wl_done, rl_done} = 2'h0;
  endtask
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (rd_valid === 1'b1)
      chk(rd_data, q.size() > 0 ? q.pop_front() : 32'hx);
    if (cyc == 4000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    {wl_done, rl_done, we, re, fwd, ecrc, aw, tl, wi, ri, ps, rs, lw} = '0;
    repeat (12) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      {wi, ri, aw, tl} = 48'({$random(seed), $random(seed)});
      {ps, rs, lw} = {3'(i), 3'(4 - i), 4'h1 << (i % 4)};
      {we, re} = {i[0], ~i[0]};
      cds_host_model_i.acc(1'b0, 8'h20);
      cds_host_model_i.acc(1'b0, 8'h2c);
      rd(8'h20, {4'h1, 4'h0, ps, 4'h0, we, wi});
      rd(8'h28, {8'h00, rs, lw, re, ri});
      rd(8'h24, {aw, 24'h0});
      rd(8'h2c, {tl, 24'h0});
      rd(8'h34, 32'h0);
    end
    run(8'h00, 20);
    rd(8'h24, {aw, 24'h15});
    rd(8'h24, {aw, 24'h15});
    run(8'h10, 5);
    rd(8'h2c, {tl, 24'h6});
    run(8'h00, 3);
    rd(8'h24, {aw, 24'h4});
    fwd = 1'b1;
    ecrc = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    fwd = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    ecrc = 1'b0;
    rd(8'h30, 32'h3);
    repeat (4) @(negedge clk_sys_in);
    chk(32'(q.size()), 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
